// ==== include/cse_pkg.sv ====
// Shared constants and types for the conditional skip execution block
package cse_pkg;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned BIT_IDX_W = 3;
	localparam int unsigned FLAG_W = 4;
	// Flag vector field positions
	localparam int unsigned FLAG_Z_POS = 0;
	localparam int unsigned FLAG_C_POS = 1;
	localparam int unsigned FLAG_NIBBLE_POS = 2;
	localparam int unsigned FLAG_WRAP_POS = 3;
	// Reset values and data constants
	localparam logic [DATA_W-1:0] WREG_RESET = 8'h00;
	localparam logic [FLAG_W-1:0] FLAGS_RESET = 4'h0;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
	localparam logic [BIT_IDX_W-1:0] BIT_RESET = 3'h0;
	// Instruction classes handed over by the sequencer
	typedef enum logic [3:0] {
		CSE_OP_OTHER = 4'h0,
		CSE_OP_CEQ_IMM = 4'h1,
		CSE_OP_CEQ_MEM = 4'h2,
		CSE_OP_CNE_MEM = 4'h3,
		CSE_OP_CNE_IMM = 4'h4,
		CSE_OP_BIT_LOW_SKIP_IO = 4'h5,
		CSE_OP_BIT_HIGH_SKIP_IO = 4'h6,
		CSE_OP_BIT_LOW_SKIP_MEM = 4'h7,
		CSE_OP_BIT_HIGH_SKIP_MEM = 4'h8,
		CSE_OP_INC_WREG = 4'h9,
		CSE_OP_DEC_WREG = 4'ha,
		CSE_OP_INC_MEM = 4'hb,
		CSE_OP_DEC_MEM = 4'hc
	} cse_op_t;
	// Gray sequence along idle, read, capture, execute
	typedef enum logic [1:0] {
		CSE_ST_IDLE = 2'h0,
		CSE_ST_READ = 2'h1,
		CSE_ST_CAPT = 2'h3,
		CSE_ST_EXEC = 2'h2
	} cse_state_t;
endpackage

// ==== design/cse_alu.sv ====
// Eight-bit add/subtract with zero, carry, nibble carry and signed wrap flags
`timescale 1ns/1ps
module cse_alu
	import cse_pkg::*;
(
	// Operands
	input wire logic [cse_pkg::DATA_W-1:0] i_a,
	input wire logic [cse_pkg::DATA_W-1:0] i_b,
	input wire logic i_sub,
	// Result
	output logic [cse_pkg::DATA_W-1:0] o_res,
	output logic [cse_pkg::FLAG_W-1:0] o_flags
);
	logic [DATA_W:0] full_sum;
	logic [4:0] nib_sum;
	logic [DATA_W-1:0] b_eff;
	logic carry_out;
	logic nib_out;

	// Subtract as a + ~b + 1; carry then reads as a borrow
	assign b_eff = i_sub ? ~i_b : i_b;
	assign full_sum = {1'b0, i_a} + {1'b0, b_eff} + {8'h00, i_sub};
	assign nib_sum = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, i_sub};
	assign o_res = full_sum[DATA_W-1:0];
	assign carry_out = full_sum[DATA_W] ^ i_sub;
	assign nib_out = nib_sum[4] ^ i_sub;
	assign o_flags[FLAG_Z_POS] = (o_res == DATA_ZERO);
	assign o_flags[FLAG_C_POS] = carry_out;
	assign o_flags[FLAG_NIBBLE_POS] = nib_out;
	assign o_flags[FLAG_WRAP_POS] = (i_a[DATA_W-1] == b_eff[DATA_W-1]) && (o_res[DATA_W-1] != i_a[DATA_W-1]);
endmodule

// ==== design/cse_exec.sv ====
// Conditional skip executor: compares, bit tests and count-and-skip on zero
//
// How it works
// - Compare working register with immediate; skip next instruction when equal.
// - Compare working register with memory byte; skip next instruction when equal.
// - Compare working register with memory byte; skip next when they differ.
// - Compare working register with immediate; skip next when they differ.
// - Compares set all four flags as a subtraction would, working register unchanged.
// - Test IO bit; skip next when it is zero; flags untouched.
// - Test IO bit; skip next when it is one; flags untouched.
// - Test memory bit; skip next when it is zero; flags untouched.
// - Test memory bit; skip next when it is one; flags untouched.
// - Increment working register, write back, set flags, skip when result zero.
// - Decrement working register, write back, set flags, skip when result zero.
// - Increment memory byte, store back, set flags, skip when result zero.
// - Decrement memory byte, store back, set flags, skip when result zero.
`timescale 1ns/1ps
module cse_exec
	import cse_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_srst,
	// Instruction issue from the sequencer
	input wire logic i_valid,
	input wire cse_pkg::cse_op_t i_op,
	input wire logic [cse_pkg::DATA_W-1:0] i_imm,
	input wire logic [cse_pkg::ADDR_W-1:0] i_addr,
	input wire logic [cse_pkg::BIT_IDX_W-1:0] i_bit_idx,
	output logic o_ready,
	output logic o_done,
	output logic o_commit,
	output logic o_squash,
	output logic o_skip_pending,
	// Working register and flag loads from other instruction classes
	input wire logic i_wreg_load,
	input wire logic [cse_pkg::DATA_W-1:0] i_wreg_value,
	input wire logic i_flags_load,
	input wire logic [cse_pkg::FLAG_W-1:0] i_flags_value,
	output logic [cse_pkg::DATA_W-1:0] o_working_register,
	output logic [cse_pkg::FLAG_W-1:0] o_flags,
	// Data memory and IO port access
	output logic [cse_pkg::ADDR_W-1:0] o_addr,
	output logic o_mem_rd,
	output logic o_io_rd,
	output logic o_mem_wr,
	output logic [cse_pkg::DATA_W-1:0] o_mem_wdata,
	input wire logic [cse_pkg::DATA_W-1:0] i_mem_rdata,
	input wire logic [cse_pkg::DATA_W-1:0] i_io_rdata
);
	import cse_pkg::*;

	cse_state_t state_r;
	cse_state_t state_nxt;
	cse_op_t op_r;
	logic [DATA_W-1:0] imm_r;
	logic [DATA_W-1:0] opnd_r;
	logic [BIT_IDX_W-1:0] bit_r;
	logic from_io_r;
	logic [DATA_W-1:0] wreg_r;
	logic [FLAG_W-1:0] flags_r;
	logic skip_r;
	logic skip_nxt;
	logic ready_r;
	logic done_r;
	logic commit_r;
	logic squash_r;
	logic [ADDR_W-1:0] addr_r;
	logic mem_rd_r;
	logic io_rd_r;
	logic mem_wr_r;
	logic [DATA_W-1:0] mem_wdata_r;

	// Issue decode
	wire taken = i_valid && ready_r;
	wire take_squash = taken && skip_r;
	wire take_other = taken && !skip_r && (i_op == CSE_OP_OTHER);
	wire need_read_i = (i_op != CSE_OP_OTHER) && (i_op != CSE_OP_CEQ_IMM) && (i_op != CSE_OP_CNE_IMM)
		&& (i_op != CSE_OP_INC_WREG) && (i_op != CSE_OP_DEC_WREG);
	wire is_io_i = (i_op == CSE_OP_BIT_LOW_SKIP_IO) || (i_op == CSE_OP_BIT_HIGH_SKIP_IO);
	wire take_read = taken && !skip_r && need_read_i;
	wire take_direct = taken && !skip_r && !need_read_i && (i_op != CSE_OP_OTHER);

	// Execute decode
	wire in_exec = (state_r == CSE_ST_EXEC);
	wire is_cmp_imm = (op_r == CSE_OP_CEQ_IMM) || (op_r == CSE_OP_CNE_IMM);
	wire is_cmp_mem = (op_r == CSE_OP_CEQ_MEM) || (op_r == CSE_OP_CNE_MEM);
	wire is_cmp = is_cmp_imm || is_cmp_mem;
	wire is_cmp_eq = (op_r == CSE_OP_CEQ_IMM) || (op_r == CSE_OP_CEQ_MEM);
	wire is_bit_low = (op_r == CSE_OP_BIT_LOW_SKIP_IO) || (op_r == CSE_OP_BIT_LOW_SKIP_MEM);
	wire is_bit_high = (op_r == CSE_OP_BIT_HIGH_SKIP_IO) || (op_r == CSE_OP_BIT_HIGH_SKIP_MEM);
	wire is_wreg_cnt = (op_r == CSE_OP_INC_WREG) || (op_r == CSE_OP_DEC_WREG);
	wire is_mem_cnt = (op_r == CSE_OP_INC_MEM) || (op_r == CSE_OP_DEC_MEM);
	wire is_dec = (op_r == CSE_OP_DEC_WREG) || (op_r == CSE_OP_DEC_MEM);
	wire is_arith = is_cmp || is_wreg_cnt || is_mem_cnt;

	// Operand steering into the adder
	wire [DATA_W-1:0] cmp_opnd = is_cmp_imm ? imm_r : opnd_r;
	wire [DATA_W-1:0] alu_a = is_mem_cnt ? opnd_r : wreg_r;
	wire [DATA_W-1:0] alu_b = is_cmp ? cmp_opnd : DATA_ONE;
	wire alu_sub = is_cmp || is_dec;
	logic [DATA_W-1:0] alu_res;
	logic [FLAG_W-1:0] alu_flags;

	// Selected bit of the fetched byte
	wire tested_bit = opnd_r[bit_r];
	wire res_zero = alu_flags[FLAG_Z_POS];
	wire operands_equal = (wreg_r == cmp_opnd);

	// Skip decision per instruction class
	wire skip_cond = (is_cmp_eq && operands_equal)
		|| (is_cmp && !is_cmp_eq && !operands_equal)
		|| (is_bit_low && !tested_bit)
		|| (is_bit_high && tested_bit)
		|| ((is_wreg_cnt || is_mem_cnt) && res_zero);

	cse_alu u_alu (
		.i_a(alu_a),
		.i_b(alu_b),
		.i_sub(alu_sub),
		.o_res(alu_res),
		.o_flags(alu_flags)
	);

	// Sequencer of one instruction
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			CSE_ST_IDLE: begin
				if (take_read) begin
					state_nxt = CSE_ST_READ;
				end else if (take_direct) begin
					state_nxt = CSE_ST_EXEC;
				end
			end
			CSE_ST_READ: begin
				state_nxt = CSE_ST_CAPT;
			end
			CSE_ST_CAPT: begin
				state_nxt = CSE_ST_EXEC;
			end
			CSE_ST_EXEC: begin
				state_nxt = CSE_ST_IDLE;
			end
			default: begin
				state_nxt = CSE_ST_IDLE;
			end
		endcase
	end

	// A pending skip is consumed by the very next issued instruction
	always_comb begin
		skip_nxt = skip_r;
		if (take_squash) begin
			skip_nxt = 1'b0;
		end else if (in_exec) begin
			skip_nxt = skip_cond;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			state_r <= CSE_ST_IDLE;
			skip_r <= 1'b0;
			ready_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			skip_r <= skip_nxt;
			ready_r <= (state_nxt == CSE_ST_IDLE);
		end
	end

	// Latch the instruction fields when an own instruction is taken with no skip pending
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			op_r <= CSE_OP_OTHER;
			imm_r <= DATA_ZERO;
			bit_r <= BIT_RESET;
			from_io_r <= 1'b0;
			addr_r <= ADDR_RESET;
		end else if (take_read || take_direct) begin
			op_r <= i_op;
			imm_r <= i_imm;
			bit_r <= i_bit_idx;
			from_io_r <= is_io_i;
			addr_r <= i_addr;
		end
	end

	// Read data stand in the cycle after the read strobe
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			opnd_r <= DATA_ZERO;
		end else if (state_r == CSE_ST_CAPT) begin
			opnd_r <= from_io_r ? i_io_rdata : i_mem_rdata;
		end
	end

	// Bus strobes, one cycle each
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			mem_rd_r <= 1'b0;
			io_rd_r <= 1'b0;
			mem_wr_r <= 1'b0;
			mem_wdata_r <= DATA_ZERO;
		end else begin
			mem_rd_r <= take_read && !is_io_i;
			io_rd_r <= take_read && is_io_i;
			mem_wr_r <= in_exec && is_mem_cnt;
			if (in_exec && is_mem_cnt) begin
				mem_wdata_r <= alu_res;
			end
		end
	end

	// Own writes win over loads arriving in the same cycle
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			wreg_r <= WREG_RESET;
		end else if (in_exec && is_wreg_cnt) begin
			wreg_r <= alu_res;
		end else if (i_wreg_load) begin
			wreg_r <= i_wreg_value;
		end
	end

	// Bit tests leave the flags alone; compares never write the working register
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			flags_r <= FLAGS_RESET;
		end else if (in_exec && is_arith) begin
			flags_r <= alu_flags;
		end else if (i_flags_load) begin
			flags_r <= i_flags_value;
		end
	end

	// Completion pulses to the sequencer
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			done_r <= 1'b0;
			commit_r <= 1'b0;
			squash_r <= 1'b0;
		end else begin
			done_r <= in_exec;
			commit_r <= take_other;
			squash_r <= take_squash;
		end
	end

	assign o_ready = ready_r;
	assign o_done = done_r;
	assign o_commit = commit_r;
	assign o_squash = squash_r;
	assign o_skip_pending = skip_r;
	assign o_working_register = wreg_r;
	assign o_flags = flags_r;
	assign o_addr = addr_r;
	assign o_mem_rd = mem_rd_r;
	assign o_io_rd = io_rd_r;
	assign o_mem_wr = mem_wr_r;
	assign o_mem_wdata = mem_wdata_r;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_srst);

	chk_ceq_imm_skip: assert property (
		in_exec && op_r == CSE_OP_CEQ_IMM |=> skip_r == ($past(wreg_r) == $past(imm_r)))
		else $error("immediate equal compare skip wrong");

	chk_ceq_mem_skip: assert property (
		in_exec && op_r == CSE_OP_CEQ_MEM |=> skip_r == ($past(wreg_r) == $past(opnd_r)))
		else $error("memory equal compare skip wrong");

	chk_cne_mem_skip: assert property (
		in_exec && op_r == CSE_OP_CNE_MEM |=> skip_r == ($past(wreg_r) != $past(opnd_r)))
		else $error("memory unequal compare skip wrong");

	chk_cne_imm_skip: assert property (
		in_exec && op_r == CSE_OP_CNE_IMM |=> skip_r == ($past(wreg_r) != $past(imm_r)))
		else $error("immediate unequal compare skip wrong");

	chk_cmp_sub_flags: assert property (
		in_exec && is_cmp && !i_wreg_load
		|=> o_flags[FLAG_Z_POS] == ($past(wreg_r) == $past(cmp_opnd))
		&& o_flags[FLAG_C_POS] == ($past(wreg_r) < $past(cmp_opnd))
		&& o_flags[FLAG_NIBBLE_POS] == ($past(wreg_r[3:0]) < $past(cmp_opnd[3:0]))
		&& $stable(o_working_register))
		else $error("compare flags or working register wrong");

	chk_io_bit_test: assert property (
		in_exec && from_io_r && !i_flags_load
		|=> $stable(o_flags) && skip_r == ($past(is_bit_high) == $past(opnd_r[bit_r])))
		else $error("io bit test wrong");

	chk_mem_bit_test: assert property (
		in_exec && (is_bit_low || is_bit_high) && !from_io_r && !i_flags_load
		|=> $stable(o_flags) && skip_r == ($past(is_bit_high) == $past(opnd_r[bit_r])))
		else $error("memory bit test wrong");

	chk_wreg_count_skip: assert property (
		in_exec && is_wreg_cnt
		|=> o_working_register == $past(is_dec ? wreg_r - DATA_ONE : wreg_r + DATA_ONE)
		&& skip_r == (o_working_register == DATA_ZERO))
		else $error("working register count skip wrong");

	chk_mem_count_skip: assert property (
		in_exec && is_mem_cnt
		|=> o_mem_wr && o_mem_wdata == $past(is_dec ? opnd_r - DATA_ONE : opnd_r + DATA_ONE)
		&& skip_r == (o_mem_wdata == DATA_ZERO) ##1 !o_mem_wr)
		else $error("memory count skip wrong");

	chk_squash_no_effect: assert property (
		take_squash |=> o_squash && !o_skip_pending && !o_mem_rd && !o_io_rd && !o_commit
		##1 !o_mem_wr && !o_done && (o_ready || $past(i_valid)))
		else $error("skipped instruction had an effect");

	chk_read_latency: assert property (
		take_read |=> (o_mem_rd || o_io_rd) ##1 (state_r == CSE_ST_CAPT) ##1 in_exec ##1 o_done)
		else $error("operand read sequence wrong");
endmodule

// ==== sim/cse_port_model.sv ====
// Behavioural data memory and IO ports seen from the conditional skip core
`timescale 1ns/1ps
module cse_port_model
	import cse_pkg::*;
(
	// Clock
	input wire logic i_sys_clk,
	// Access strobes from the core
	input wire logic [cse_pkg::ADDR_W-1:0] i_addr,
	input wire logic i_mem_rd,
	input wire logic i_io_rd,
	input wire logic i_mem_wr,
	input wire logic [cse_pkg::DATA_W-1:0] i_mem_wdata,
	// Read data back to the core
	output logic [cse_pkg::DATA_W-1:0] o_mem_rdata,
	output logic [cse_pkg::DATA_W-1:0] o_io_rdata
);
	logic [DATA_W-1:0] mem [0:255];
	logic [DATA_W-1:0] io [0:255];
	int wr_cnt = 0;
	initial begin
		o_mem_rdata = 8'h00;
		o_io_rdata = 8'h00;
	end
	// Data valid only in the cycle after a strobe; inverted otherwise so a late capture shows
	always @(posedge i_sys_clk) begin
		o_mem_rdata <= i_mem_rd ? mem[i_addr] : ~o_mem_rdata;
		o_io_rdata <= i_io_rd ? io[i_addr] : ~o_io_rdata;
		if (i_mem_wr) begin
			mem[i_addr] <= i_mem_wdata;
			wr_cnt <= wr_cnt + 1;
		end
	end
endmodule

// ==== sim/conditional_skip_exec_test.sv ====
// Self-checking bench for the conditional skip executor
`timescale 1ns/1ps
module conditional_skip_exec_test;
	import cse_pkg::*;
	localparam logic [ADDR_W-1:0] ADDR = 8'h5a;
	logic i_sys_clk, i_srst, i_valid, i_wreg_load, i_flags_load;
	cse_op_t i_op;
	logic [DATA_W-1:0] i_imm, i_wreg_value, o_working_register, o_mem_wdata, i_mem_rdata, i_io_rdata;
	logic [ADDR_W-1:0] i_addr, o_addr;
	logic [BIT_IDX_W-1:0] i_bit_idx;
	logic [FLAG_W-1:0] i_flags_value, o_flags;
	logic o_ready, o_done, o_commit, o_squash, o_skip_pending, o_mem_rd, o_io_rd, o_mem_wr;
	int error_cnt = 0;
	int checked = 0;
	int cycles = 0;
	logic [2:0] seen_top;

	cse_exec uut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_valid(i_valid), .i_op(i_op), .i_imm(i_imm),
		.i_addr(i_addr), .i_bit_idx(i_bit_idx), .o_ready(o_ready), .o_done(o_done), .o_commit(o_commit),
		.o_squash(o_squash), .o_skip_pending(o_skip_pending), .i_wreg_load(i_wreg_load),
		.i_wreg_value(i_wreg_value), .i_flags_load(i_flags_load), .i_flags_value(i_flags_value),
		.o_working_register(o_working_register), .o_flags(o_flags), .o_addr(o_addr), .o_mem_rd(o_mem_rd),
		.o_io_rd(o_io_rd), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata),
		.i_io_rdata(i_io_rdata));

	cse_port_model mdl (.i_sys_clk(i_sys_clk), .i_addr(o_addr), .i_mem_rd(o_mem_rd), .i_io_rd(o_io_rd),
		.i_mem_wr(o_mem_wr), .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata), .o_io_rdata(i_io_rdata));

	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	task automatic close_out();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Hang guard, far above the few hundred cycles the sequence needs
	always @(posedge i_sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			error_cnt++;
			close_out();
		end
	end

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (exp !== got) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Returns {wrap, nibble carry, carry, zero, result}
	function automatic logic [11:0] alu(input logic [7:0] a, input logic [7:0] b, input logic s);
		logic [8:0] r;
		logic [4:0] n;
		logic ov;
		r = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
		n = s ? {1'b0, a[3:0]} - {1'b0, b[3:0]} : {1'b0, a[3:0]} + {1'b0, b[3:0]};
		ov = s ? (a[7] != b[7] && r[7] != a[7]) : (a[7] == b[7] && r[7] != a[7]);
		return {ov, n[4], r[8], r[7:0] == 8'h00, r[7:0]};
	endfunction

	// Offer one instruction, hold it over the take edge, then wait for its answer pulse
	task automatic issue(input cse_op_t op, input logic [7:0] imm, input logic [2:0] bi, output logic [2:0] seen);
		int n;
		@(posedge i_sys_clk);
		i_valid <= 1'b1;
		i_op <= op;
		i_imm <= imm;
		i_addr <= ADDR;
		i_bit_idx <= bi;
		@(posedge i_sys_clk);
		i_valid <= 1'b0;
		seen = 3'h0;
		for (n = 0; n < 8 && seen == 3'h0; n++) begin
			#1 seen = {o_commit, o_squash, o_done};
			if (seen == 3'h0) @(posedge i_sys_clk);
		end
	endtask

	// Known working register and flags before each case
	task automatic preset(input logic [7:0] w);
		@(posedge i_sys_clk);
		i_wreg_load <= 1'b1;
		i_wreg_value <= w;
		i_flags_load <= 1'b1;
		i_flags_value <= 4'h5;
		@(posedge i_sys_clk);
		i_wreg_load <= 1'b0;
		i_flags_load <= 1'b0;
	endtask

	// One own instruction followed by a foreign one that must be squashed or committed
	task automatic run(input cse_op_t op, input logic [7:0] w, input logic [7:0] v, input logic [2:0] bi);
		logic [11:0] r;
		logic [2:0] seen;
		logic skip;
		logic [7:0] ew, em;
		logic [3:0] ef;
		int wc;
		preset(w);
		mdl.mem[ADDR] = v;
		mdl.io[ADDR] = ~v;
		if (op == CSE_OP_BIT_LOW_SKIP_IO || op == CSE_OP_BIT_HIGH_SKIP_IO) mdl.io[ADDR] = v;
		if (op == CSE_OP_BIT_LOW_SKIP_IO || op == CSE_OP_BIT_HIGH_SKIP_IO) mdl.mem[ADDR] = ~v;
		wc = mdl.wr_cnt;
		ew = w;
		em = mdl.mem[ADDR];
		ef = 4'h5;
		case (op)
			CSE_OP_CEQ_IMM, CSE_OP_CEQ_MEM, CSE_OP_CNE_MEM, CSE_OP_CNE_IMM: begin
				r = alu(w, v, 1'b1);
				ef = r[11:8];
				skip = (w == v) ^ (op == CSE_OP_CNE_MEM || op == CSE_OP_CNE_IMM);
			end
			CSE_OP_INC_WREG, CSE_OP_DEC_WREG: begin
				{ef, ew} = alu(w, 8'h01, op == CSE_OP_DEC_WREG);
				skip = ew == 8'h00;
			end
			CSE_OP_INC_MEM, CSE_OP_DEC_MEM: begin
				{ef, em} = alu(v, 8'h01, op == CSE_OP_DEC_MEM);
				skip = em == 8'h00;
			end
			default: skip = v[bi] ^ (op == CSE_OP_BIT_LOW_SKIP_IO || op == CSE_OP_BIT_LOW_SKIP_MEM);
		endcase
		issue(op, v, bi, seen);
		chk("done", 8'h01, {5'h00, seen});
		chk("skip_pending", {7'h00, skip}, {7'h00, o_skip_pending});
		chk("flags", {4'h0, ef}, {4'h0, o_flags});
		chk("working_register", ew, o_working_register);
		chk("address", ADDR, o_addr);
		issue(CSE_OP_OTHER, 8'h00, 3'h0, seen);
		chk("follower", skip ? 8'h02 : 8'h04, {5'h00, seen});
		chk("flags after", {4'h0, ef}, {4'h0, o_flags});
		chk("wreg after", ew, o_working_register);
		chk("memory", em, mdl.mem[ADDR]);
		chk("writes", 8'(wc + (op == CSE_OP_INC_MEM || op == CSE_OP_DEC_MEM)), 8'(mdl.wr_cnt));
	endtask

	initial begin
		i_srst = 1'b1;
		i_valid = 1'b0;
		i_op = CSE_OP_OTHER;
		i_imm = 8'h00;
		i_addr = 8'h00;
		i_bit_idx = 3'h0;
		i_wreg_load = 1'b0;
		i_wreg_value = 8'h00;
		i_flags_load = 1'b0;
		i_flags_value = 4'h0;
		repeat (5) @(posedge i_sys_clk);
		i_srst <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		#1 chk("ready", 8'h01, {7'h00, o_ready});
		chk("reset flags", {4'h0, FLAGS_RESET}, {4'h0, o_flags});
		chk("reset wreg", WREG_RESET, o_working_register);
		run(CSE_OP_CEQ_IMM, 8'h55, 8'h55, 3'h0);
		run(CSE_OP_CEQ_IMM, 8'h55, 8'h56, 3'h0);
		run(CSE_OP_CEQ_MEM, 8'h80, 8'h01, 3'h0);
		run(CSE_OP_CEQ_MEM, 8'h3c, 8'h3c, 3'h0);
		run(CSE_OP_CNE_MEM, 8'h10, 8'h01, 3'h0);
		run(CSE_OP_CNE_MEM, 8'h7f, 8'h7f, 3'h0);
		run(CSE_OP_CNE_IMM, 8'h00, 8'h01, 3'h0);
		run(CSE_OP_CNE_IMM, 8'haa, 8'haa, 3'h0);
		run(CSE_OP_BIT_LOW_SKIP_IO, 8'h11, 8'hfe, 3'h0);
		run(CSE_OP_BIT_LOW_SKIP_IO, 8'h11, 8'h80, 3'h7);
		run(CSE_OP_BIT_HIGH_SKIP_IO, 8'h22, 8'h20, 3'h5);
		run(CSE_OP_BIT_HIGH_SKIP_IO, 8'h22, 8'hfd, 3'h1);
		run(CSE_OP_BIT_LOW_SKIP_MEM, 8'h33, 8'h7f, 3'h7);
		run(CSE_OP_BIT_LOW_SKIP_MEM, 8'h33, 8'h40, 3'h6);
		run(CSE_OP_BIT_HIGH_SKIP_MEM, 8'h44, 8'hf7, 3'h3);
		run(CSE_OP_BIT_HIGH_SKIP_MEM, 8'h44, 8'h04, 3'h2);
		run(CSE_OP_INC_WREG, 8'hff, 8'h00, 3'h0);
		run(CSE_OP_INC_WREG, 8'h7f, 8'h00, 3'h0);
		run(CSE_OP_DEC_WREG, 8'h01, 8'h00, 3'h0);
		run(CSE_OP_DEC_WREG, 8'h00, 8'h00, 3'h0);
		run(CSE_OP_INC_MEM, 8'h66, 8'hff, 3'h0);
		run(CSE_OP_INC_MEM, 8'h66, 8'h0f, 3'h0);
		run(CSE_OP_DEC_MEM, 8'h77, 8'h01, 3'h0);
		run(CSE_OP_DEC_MEM, 8'h77, 8'h80, 3'h0);
		// A skipped own memory instruction must leave memory, flags and register alone
		preset(8'h09);
		mdl.mem[ADDR] = 8'h33;
		issue(CSE_OP_CEQ_IMM, 8'h09, 3'h0, seen_top);
		issue(CSE_OP_INC_MEM, 8'h00, 3'h0, seen_top);
		chk("squashed own", 8'h02, {5'h00, seen_top});
		repeat (3) @(posedge i_sys_clk);
		#1 chk("squashed memory", 8'h33, mdl.mem[ADDR]);
		chk("squashed flags", 8'h01, {4'h0, o_flags});
		chk("squashed wreg", 8'h09, o_working_register);
		close_out();
	end
endmodule
